// ---- common/qpf_pkg.sv ----
package qpf_pkg;
    // program counter and vectors
    localparam int          QPF_PC_W        = 13;
    localparam int          QPF_IR_W        = 14;
    localparam logic [12:0] QPF_RESET_VEC   = 13'h0000;
    localparam logic [12:0] QPF_INT_VEC     = 13'h0004;
    localparam logic [12:0] QPF_MASK_512    = 13'h01ff;
    localparam logic [12:0] QPF_MASK_1K     = 13'h03ff;
    localparam logic [12:0] QPF_MASK_2K     = 13'h07ff;
    // size variant: largest part, bank-1 storage present
    localparam logic [12:0] QPF_PROG_MASK   = QPF_MASK_2K;
    localparam logic        QPF_LARGE       = 1'b1;
    localparam int          QPF_GPR_DEPTH   = QPF_LARGE ? 128 : 96;
    // data-memory map (low seven address bits)
    localparam logic [6:0]  QPF_A_INDIRECT  = 7'h00;
    localparam logic [6:0]  QPF_A_PC_LOW    = 7'h02;
    localparam logic [6:0]  QPF_A_STATUS    = 7'h03;
    localparam logic [6:0]  QPF_A_FSEL      = 7'h04;
    localparam logic [6:0]  QPF_A_PC_LATCH  = 7'h0a;
    localparam logic [6:0]  QPF_A_INTCTL    = 7'h0b;
    localparam logic [6:0]  QPF_SFR_TOP     = 7'h20;
    localparam logic [6:0]  QPF_SHARED_LO   = 7'h70;
    localparam logic [6:0]  QPF_B1_GPR_END  = 7'h40;
    localparam logic [6:0]  QPF_B1_IDX_OFF  = 7'h40;
    // register fields and reset values
    localparam int          QPF_BANK_BIT    = 5;
    localparam int          QPF_GIE_BIT     = 7;
    localparam logic [7:0]  QPF_STATUS_RST  = 8'h18;
    localparam logic [7:0]  QPF_STATUS_RO   = 8'h18;
    localparam logic [7:0]  QPF_REG_RST     = 8'h00;
    // instruction classes
    localparam logic [2:0]  QPF_OP_JUMP     = 3'b101;
    localparam logic [1:0]  QPF_OP_FILE     = 2'b00;
    localparam int          QPF_DEST_BIT    = 7;
    // bus map and answers
    localparam int          QPF_AXI_AW      = 12;
    localparam logic [11:0] QPF_AXI_CTRL    = 12'h400;
    localparam logic [11:0] QPF_AXI_INFO    = 12'h404;
    localparam logic [1:0]  QPF_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  QPF_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        QPF_PH_ONE, QPF_PH_TWO, QPF_PH_THREE, QPF_PH_FOUR
    } qpf_phase_t;

    typedef enum logic [2:0] {
        QPF_K_NONE, QPF_K_GPR, QPF_K_PC_LOW, QPF_K_STATUS,
        QPF_K_FSEL, QPF_K_PC_LATCH, QPF_K_INTCTL, QPF_K_INDIRECT
    } qpf_kind_t;
endpackage

// ---- rtl/qpf_core.sv ----
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
// Operation
// - input clock divided by four into four phases forming one cycle
// - program counter advances once per cycle, on phase one
// - fetched instruction word captured in phase four
// - fetched word reaches execution at phase one, executes phases two-four
// - fetch and execute overlap, one plain instruction per cycle
// - operand read in phase two, result written in phase four
// - pc-changing instructions take two cycles, fetched word discarded
// - program counter is 13 bits, 8K word space of 14 bits
// - addresses above implemented program top wrap around
// - reset starts at 0000h, interrupt entry loads 0004h
// - bank-select bit 5 of status picks bank 0 or bank 1
// - first 32 addresses of each bank are special registers
// - 20h-7Fh bank 0 is storage, A0h-BFh too on largest part
// - bank-1 F0h-FFh alias bank-0 70h-7Fh
// - storage holds 96 bytes, or 128 on largest part
// - every storage byte reachable directly and through indirect pointer
// - cycle-rate output toggles at one quarter of input clock
module qpf_core
    import qpf_pkg::*;
(
    input  wire logic                      I_MCLK,
    input  wire logic                      I_RST_B,
    input  wire logic                      I_IRQ,
    input  wire logic [qpf_pkg::QPF_IR_W-1:0] I_PROG_DATA,
    output logic      [qpf_pkg::QPF_PC_W-1:0] O_PROG_ADDR,
    output logic      [3:0]                O_PHASE,
    output logic                           O_CYCLE_RATE,
    input  wire logic [qpf_pkg::QPF_AXI_AW-1:0] I_AWADDR,
    input  wire logic                      I_AWVALID,
    output logic                           O_AWREADY,
    input  wire logic [31:0]               I_WDATA,
    input  wire logic [3:0]                I_WSTRB,
    input  wire logic                      I_WVALID,
    output logic                           O_WREADY,
    output logic [1:0]                     O_BRESP,
    output logic                           O_BVALID,
    input  wire logic                      I_BREADY,
    input  wire logic [qpf_pkg::QPF_AXI_AW-1:0] I_ARADDR,
    input  wire logic                      I_ARVALID,
    output logic                           O_ARREADY,
    output logic [31:0]                    O_RDATA,
    output logic [1:0]                     O_RRESP,
    output logic                           O_RVALID,
    input  wire logic                      I_RREADY
);
    import qpf_pkg::*;

    typedef struct packed {
        qpf_phase_t                   phase;
        logic                         init;
        logic                         run;
        logic [QPF_PC_W-1:0]          pc;
        logic [QPF_IR_W-1:0]          fetch_ir;
        logic [QPF_IR_W-1:0]          exec_ir;
        logic                         exec_valid;
        logic [7:0]                   operand;
        logic [7:0]                   op_addr;
        logic                         branch_pend;
        logic [QPF_PC_W-1:0]          branch_tgt;
        logic [7:0]                   status;
        logic [7:0]                   fsel;
        logic [7:0]                   pc_latch;
        logic [7:0]                   intctl;
        logic [QPF_GPR_DEPTH-1:0][7:0] gpr;
        logic                         aw_got;
        logic                         awready;
        logic [QPF_AXI_AW-1:0]        awaddr;
        logic                         w_got;
        logic                         wready;
        logic [7:0]                   wdata;
        logic                         wlane0;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         ar_got;
        logic                         arready;
        logic [QPF_AXI_AW-1:0]        araddr;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
        logic [3:0]                   phase_oh;
        logic                         cycle_out;
    } qpf_state_t;

    qpf_state_t s_ff;
    qpf_state_t nxt_s;

    // address decode, same core registers in both banks
    function automatic qpf_kind_t dm_kind(input logic [7:0] a);
        logic [6:0] lo;
        lo = a[6:0];
        if (lo < QPF_SFR_TOP) begin
            unique case (lo)
                QPF_A_INDIRECT: dm_kind = QPF_K_INDIRECT;
                QPF_A_PC_LOW:   dm_kind = QPF_K_PC_LOW;
                QPF_A_STATUS:   dm_kind = QPF_K_STATUS;
                QPF_A_FSEL:     dm_kind = QPF_K_FSEL;
                QPF_A_PC_LATCH: dm_kind = QPF_K_PC_LATCH;
                QPF_A_INTCTL:   dm_kind = QPF_K_INTCTL;
                default:        dm_kind = QPF_K_NONE;
            endcase
        end else if (!a[7] || lo >= QPF_SHARED_LO) begin
            dm_kind = QPF_K_GPR;
        end else if (QPF_LARGE && lo < QPF_B1_GPR_END) begin
            dm_kind = QPF_K_GPR;
        end else begin
            dm_kind = QPF_K_NONE;
        end
    endfunction

    // bank 0 at 0..95, bank-1 storage at 96..127, alias folds onto bank 0
    function automatic logic [6:0] dm_index(input logic [7:0] a);
        if (!a[7] || a[6:0] >= QPF_SHARED_LO) begin
            dm_index = a[6:0] - QPF_SFR_TOP;
        end else begin
            dm_index = a[6:0] + QPF_B1_IDX_OFF;
        end
    endfunction

    // indirect port redirects through the pointer, one level only
    function automatic logic [7:0] dm_eff(input logic [7:0] a, input logic [7:0] ptr);
        if (a[6:0] == QPF_A_INDIRECT) begin
            dm_eff = ptr;
        end else begin
            dm_eff = a;
        end
    endfunction

    function automatic logic [7:0] dm_read(input qpf_state_t st, input logic [7:0] a);
        unique case (dm_kind(a))
            QPF_K_GPR:      dm_read = st.gpr[dm_index(a)];
            QPF_K_PC_LOW:   dm_read = st.pc[7:0];
            QPF_K_STATUS:   dm_read = st.status;
            QPF_K_FSEL:     dm_read = st.fsel;
            QPF_K_PC_LATCH: dm_read = st.pc_latch;
            QPF_K_INTCTL:   dm_read = st.intctl;
            default:        dm_read = 8'h00;
        endcase
    endfunction

    // next-state logic for phases, pipeline, data memory and bus
    always_comb begin
        logic       wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] dir_addr;
        logic [7:0] bus_addr;
        logic       axi_slot;
        wr_en    = 1'b0;
        wr_addr  = 8'h00;
        wr_data  = 8'h00;
        dir_addr = {s_ff.status[QPF_BANK_BIT], s_ff.exec_ir[6:0]};
        bus_addr = 8'h00;
        nxt_s    = s_ff;
        // bus accesses land in phase three, or on any clock while stopped, clear of core reads and writes
        axi_slot = (s_ff.phase == QPF_PH_THREE) || !s_ff.run;

        // divide by four: phase steps every clock while running
        if (s_ff.run) begin
            nxt_s.phase = qpf_phase_t'(s_ff.phase + 2'd1);
        end

        if (s_ff.run) begin
            unique case (s_ff.phase)
                QPF_PH_ONE: begin
                    if (s_ff.init) begin
                        nxt_s.pc         = QPF_RESET_VEC;
                        nxt_s.init       = 1'b0;
                        nxt_s.exec_valid = 1'b0;
                    end else if (s_ff.branch_pend) begin
                        // second cycle of a branch: fetched word dropped
                        nxt_s.pc          = s_ff.branch_tgt & QPF_PROG_MASK;
                        nxt_s.exec_valid  = 1'b0;
                        nxt_s.branch_pend = 1'b0;
                    end else if (I_IRQ && s_ff.intctl[QPF_GIE_BIT]) begin
                        // no stack here; clearing enable stops re-entry
                        nxt_s.pc                  = QPF_INT_VEC;
                        nxt_s.exec_valid          = 1'b0;
                        nxt_s.intctl[QPF_GIE_BIT] = 1'b0;
                    end else begin
                        nxt_s.pc = (s_ff.pc + 13'h0001) & QPF_PROG_MASK;
                        nxt_s.exec_ir    = s_ff.fetch_ir;
                        nxt_s.exec_valid = 1'b1;
                    end
                end
                QPF_PH_TWO: begin
                    if (s_ff.exec_valid && s_ff.exec_ir[13:12] == QPF_OP_FILE) begin
                        nxt_s.op_addr = dm_eff(dir_addr, s_ff.fsel);
                        nxt_s.operand = dm_read(s_ff, dm_eff(dir_addr, s_ff.fsel));
                    end
                end
                QPF_PH_THREE: begin
                    nxt_s.op_addr = s_ff.op_addr;
                end
                QPF_PH_FOUR: begin
                    nxt_s.fetch_ir = I_PROG_DATA;
                    if (s_ff.exec_valid && s_ff.exec_ir[13:11] == QPF_OP_JUMP) begin
                        nxt_s.branch_pend = 1'b1;
                        nxt_s.branch_tgt  = {s_ff.pc_latch[4:3], s_ff.exec_ir[10:0]};
                    end else if (s_ff.exec_valid && s_ff.exec_ir[13:12] == QPF_OP_FILE
                                 && s_ff.exec_ir[QPF_DEST_BIT]) begin
                        // stand-in operation: increment the file byte
                        wr_en   = 1'b1;
                        wr_addr = s_ff.op_addr;
                        wr_data = s_ff.operand + 8'h01;
                    end
                end
            endcase
        end

        // bus write channel: address and data taken in either order
        if (s_ff.awready && I_AWVALID) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = I_AWADDR;
        end
        if (s_ff.wready && I_WVALID) begin
            nxt_s.w_got  = 1'b1;
            nxt_s.wdata  = I_WDATA[7:0];
            nxt_s.wlane0 = I_WSTRB[0];
        end
        if (s_ff.bvalid && I_BREADY) begin
            nxt_s.bvalid = 1'b0;
        end
        if (axi_slot && s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got  = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp  = QPF_RESP_OKAY;
            if (s_ff.awaddr < QPF_AXI_CTRL) begin
                bus_addr = s_ff.awaddr[9:2];
                wr_en    = s_ff.wlane0;
                wr_addr  = dm_eff(bus_addr, s_ff.fsel);
                wr_data  = s_ff.wdata;
            end else if (s_ff.awaddr == QPF_AXI_CTRL) begin
                if (s_ff.wlane0) begin
                    nxt_s.run = s_ff.wdata[0];
                end
            end else if (s_ff.awaddr != QPF_AXI_INFO) begin
                nxt_s.bresp = QPF_RESP_SLVERR;
            end
        end

        // bus read channel
        if (s_ff.arready && I_ARVALID) begin
            nxt_s.ar_got = 1'b1;
            nxt_s.araddr = I_ARADDR;
        end
        if (s_ff.rvalid && I_RREADY) begin
            nxt_s.rvalid = 1'b0;
        end
        if (axi_slot && s_ff.ar_got && !s_ff.rvalid) begin
            nxt_s.ar_got = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = QPF_RESP_OKAY;
            nxt_s.rdata  = 32'h0000_0000;
            if (s_ff.araddr < QPF_AXI_CTRL) begin
                bus_addr    = s_ff.araddr[9:2];
                nxt_s.rdata = {24'h00_0000, dm_read(s_ff, dm_eff(bus_addr, s_ff.fsel))};
            end else if (s_ff.araddr == QPF_AXI_CTRL) begin
                nxt_s.rdata = {31'h0000_0000, s_ff.run};
            end else if (s_ff.araddr == QPF_AXI_INFO) begin
                nxt_s.rdata = {15'h0000, s_ff.branch_pend, s_ff.exec_valid,
                               s_ff.phase, s_ff.pc};
            end else begin
                nxt_s.rresp = QPF_RESP_SLVERR;
            end
        end
        // ready drops while a request waits, so nothing is overwritten
        nxt_s.awready = !nxt_s.aw_got;
        nxt_s.wready  = !nxt_s.w_got;
        nxt_s.arready = !nxt_s.ar_got;

        // single data-memory write port, core and bus never share a cycle
        if (wr_en) begin
            unique case (dm_kind(wr_addr))
                QPF_K_GPR:      nxt_s.gpr[dm_index(wr_addr)] = wr_data;
                QPF_K_PC_LOW: begin
                    // writing the low byte is a branch
                    nxt_s.branch_pend = 1'b1;
                    nxt_s.branch_tgt  = {s_ff.pc_latch[4:0], wr_data};
                end
                QPF_K_STATUS:   nxt_s.status = (wr_data & ~QPF_STATUS_RO)
                                             | (s_ff.status & QPF_STATUS_RO);
                QPF_K_FSEL:     nxt_s.fsel     = wr_data;
                QPF_K_PC_LATCH: nxt_s.pc_latch = wr_data;
                QPF_K_INTCTL:   nxt_s.intctl   = wr_data;
                default:        nxt_s.fsel     = s_ff.fsel;
            endcase
        end

        // phase strobes and quarter-rate clock output
        nxt_s.phase_oh  = 4'(4'b0001 << nxt_s.phase);
        nxt_s.cycle_out = (nxt_s.phase == QPF_PH_THREE)
                       || (nxt_s.phase == QPF_PH_FOUR);
    end

    // state register
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            s_ff          <= '0;
            s_ff.phase    <= QPF_PH_ONE;
            s_ff.init     <= 1'b1;
            s_ff.run      <= 1'b1;
            s_ff.pc       <= QPF_RESET_VEC;
            s_ff.status   <= QPF_STATUS_RST;
            s_ff.fsel     <= QPF_REG_RST;
            s_ff.pc_latch <= QPF_REG_RST;
            s_ff.intctl   <= QPF_REG_RST;
            s_ff.awready  <= 1'b1;
            s_ff.wready   <= 1'b1;
            s_ff.arready  <= 1'b1;
            s_ff.phase_oh <= 4'b0001;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs come straight from the state register
    assign O_PROG_ADDR  = s_ff.pc;
    assign O_PHASE      = s_ff.phase_oh;
    assign O_CYCLE_RATE = s_ff.cycle_out;
    assign O_AWREADY    = s_ff.awready;
    assign O_WREADY     = s_ff.wready;
    assign O_BVALID     = s_ff.bvalid;
    assign O_BRESP      = s_ff.bresp;
    assign O_ARREADY    = s_ff.arready;
    assign O_RVALID     = s_ff.rvalid;
    assign O_RDATA      = s_ff.rdata;
    assign O_RRESP      = s_ff.rresp;

    // checks on phase sequencing and pipeline timing
    AST_PHASE_STEP: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        s_ff.run && $past(s_ff.run) && $past(I_RST_B)
        |-> s_ff.phase == qpf_phase_t'($past(s_ff.phase) + 2'd1))
        else $error("phase did not step by one");

    AST_CYCLE_RATE: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        O_PHASE[1] ##1 O_PHASE[2] |-> O_CYCLE_RATE && !$past(O_CYCLE_RATE))
        else $error("cycle-rate output out of step with phases");

    AST_PC_ON_ONE: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        $past(I_RST_B) && s_ff.pc != $past(s_ff.pc) |-> $past(s_ff.phase) == QPF_PH_ONE)
        else $error("program counter moved outside phase one");

    AST_FETCH_FOUR: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        $past(I_RST_B) && $past(s_ff.run) && $past(s_ff.phase) == QPF_PH_FOUR
        |-> s_ff.fetch_ir == $past(I_PROG_DATA))
        else $error("instruction not captured in phase four");

    AST_EXEC_ONE: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        $past(I_RST_B) && s_ff.exec_ir != $past(s_ff.exec_ir)
        |-> $past(s_ff.phase) == QPF_PH_ONE && s_ff.exec_ir == $past(s_ff.fetch_ir))
        else $error("execution word changed outside phase one");

    AST_OPERAND_TWO: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        $past(I_RST_B) && s_ff.operand != $past(s_ff.operand)
        |-> $past(s_ff.phase) == QPF_PH_TWO)
        else $error("operand read outside phase two");

    AST_PC_STEP: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        s_ff.run && s_ff.phase == QPF_PH_ONE && !s_ff.init && !s_ff.branch_pend && !I_IRQ
        |=> s_ff.pc == (($past(s_ff.pc) + 13'h0001) & QPF_PROG_MASK) && s_ff.exec_valid)
        else $error("plain instruction did not advance by one");

    AST_BRANCH_FLUSH: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        s_ff.run && s_ff.phase == QPF_PH_ONE && !s_ff.init && s_ff.branch_pend
        |=> !s_ff.exec_valid && s_ff.pc == ($past(s_ff.branch_tgt) & QPF_PROG_MASK)
            ##4 (s_ff.exec_valid || !$past(s_ff.run) || $past(s_ff.phase) != QPF_PH_ONE
                 || $past(s_ff.branch_pend) || $past(I_IRQ)))
        else $error("branch did not flush and redirect");

    AST_PC_WRAP: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        (s_ff.pc & ~QPF_PROG_MASK) == 13'h0000)
        else $error("program counter above implemented space");

    AST_RESET_VEC: assert property (@(posedge I_MCLK)
        !$past(I_RST_B) && I_RST_B |-> s_ff.pc == QPF_RESET_VEC && s_ff.init)
        else $error("reset did not load the reset vector");

    AST_INT_VEC: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
        s_ff.run && s_ff.phase == QPF_PH_ONE && !s_ff.init && !s_ff.branch_pend
        && I_IRQ && s_ff.intctl[QPF_GIE_BIT] |=> s_ff.pc == QPF_INT_VEC)
        else $error("interrupt entry missed its vector");

endmodule // qpf_core

// ---- verif/qpf_prog_model.sv ----
`timescale 1ns/1ns
// program store; all 13 address bits decoded so a missing wrap shows up
module qpf_prog_model
    import qpf_pkg::*;
(
    input  wire logic [qpf_pkg::QPF_PC_W-1:0] i_addr,
    input  wire logic                         i_patch,
    output logic      [qpf_pkg::QPF_IR_W-1:0] o_word
);
    // fixed program; i_patch turns word 1 into a jump to a self-loop
    always_comb begin
        case (i_addr)
            13'h0000: o_word = 14'h00a0; // bump file 20h
            13'h0001: o_word = i_patch ? 14'h2810 : 14'h2ffe;
            13'h0002: o_word = 14'h00a1; // must be flushed
            13'h0010: o_word = 14'h2810;
            default:  o_word = 14'h3fff; // no-op
        endcase
    end
endmodule // qpf_prog_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module testbench;
    import qpf_pkg::*;
    logic        I_MCLK = 0, I_RST_B = 0, patch = 0, mon = 0, saw_wrap = 0, irq = 0;
    logic [11:0] I_AWADDR = '0, I_ARADDR = '0;
    logic        I_AWVALID = 0, I_WVALID = 0, I_ARVALID = 0;
    logic [31:0] I_WDATA = '0, seed = 32'h3ea0, r;
    logic [12:0] O_PROG_ADDR, pc_q, pc_h;
    logic [13:0] prog;
    logic [3:0]  O_PHASE, ph_q, strb = 4'hf;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [31:0] O_RDATA;
    logic [7:0]  idx;
    logic        O_CYCLE_RATE, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    int          n_fail = 0, n_tests = 0, n, i;

    always #10 I_MCLK = ~I_MCLK;

    // ready lines held high: the bus allows it and it keeps drivers race-free
    qpf_core DUT (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_IRQ(irq), .I_PROG_DATA(prog),
        .O_PROG_ADDR(O_PROG_ADDR), .O_PHASE(O_PHASE), .O_CYCLE_RATE(O_CYCLE_RATE),
        .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
        .I_WDATA(I_WDATA), .I_WSTRB(strb), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
        .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(1'b1), .I_ARADDR(I_ARADDR),
        .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
        .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(1'b1));
    qpf_prog_model u_mem (.i_addr(O_PROG_ADDR), .i_patch(patch), .o_word(prog));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // storage read-back: bank-1 c0h-efh is not implemented and reads zero
    function automatic logic [31:0] exp_rd(logic [7:0] a, logic [31:0] d);
        return (a < 8'hc0 || a >= 8'hf0) ? {24'h0, d[7:0]} : 32'h0;
    endfunction

    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        I_AWADDR <= a; I_AWVALID <= 1; I_WDATA <= d; I_WVALID <= 1;
        for (n = 0; n < 60; n++) begin
            @(posedge I_MCLK);
            if (I_AWVALID && O_AWREADY) I_AWVALID <= 0;
            if (I_WVALID && O_WREADY) I_WVALID <= 0;
            if (O_BVALID) break;
        end
        if (n == 60) begin n_fail++; conclude(); end
        `CHK(O_BRESP, QPF_RESP_OKAY)
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        I_ARADDR <= a; I_ARVALID <= 1;
        for (n = 0; n < 60; n++) begin
            @(posedge I_MCLK);
            if (I_ARVALID && O_ARREADY) I_ARVALID <= 0;
            if (O_RVALID) break;
        end
        if (n == 60) begin n_fail++; conclude(); end
        `CHK(O_RDATA, ed)
        `CHK(O_RRESP, er)
    endtask

    task automatic wait_pc(input logic [12:0] a);
        for (i = 0; i < 300 && O_PROG_ADDR !== a; i++) @(posedge I_MCLK);
        if (i == 300) begin n_fail++; conclude(); end
    endtask

    // phase rotation, cycle-rate pin and pc timing watched every clock
    always @(posedge I_MCLK) begin
        if (mon) begin
            `CHK(O_PHASE, {ph_q[2:0], ph_q[3]})
            `CHK(O_CYCLE_RATE, O_PHASE[2] | O_PHASE[3])
            if (O_PROG_ADDR !== pc_q) begin
                `CHK(O_PHASE, 4'b0010)
                if (pc_q === 13'h07ff) begin
                    saw_wrap = 1;
                    `CHK(O_PROG_ADDR, QPF_RESET_VEC)
                end
            end
        end
        ph_q = O_PHASE;
        pc_q = O_PROG_ADDR;
    end

    initial begin
        repeat (10) @(posedge I_MCLK);
        `CHK(O_PROG_ADDR, QPF_RESET_VEC)
        `CHK(O_PHASE, 4'b0001)
        I_RST_B <= 1;
        @(posedge I_MCLK);
        mon <= 1;
        // first pass bumps 20h in bank 0, second pass lands in bank 1
        wait_pc(13'h07fe);
        patch <= 1;
        wr(12'h00c, 32'h20);
        rd(12'h00c, 32'h38, QPF_RESP_OKAY);
        wait_pc(13'h0010);
        rd(12'h080, 32'h1, QPF_RESP_OKAY);
        rd(12'h280, 32'h1, QPF_RESP_OKAY);
        rd(12'h084, 32'h0, QPF_RESP_OKAY);
        // interrupt entry taken from the self-loop once the enable is set
        wr(12'h02c, 32'h80);
        irq <= 1;
        wait_pc(QPF_INT_VEC);
        irq <= 0;
        `CHK(O_PROG_ADDR, QPF_INT_VEC)
        rd(12'h02c, 32'h0, QPF_RESP_OKAY);
        `CHK(saw_wrap, 1'b1)
        wr(12'h010, 32'h25);
        rd(12'h210, 32'h25, QPF_RESP_OKAY);
        wr(12'h200, 32'h5a);
        rd(12'h094, 32'h5a, QPF_RESP_OKAY);
        // lane 0 strobe low: answered but the byte must stay
        strb <= 4'he;
        wr(12'h094, 32'ha5);
        strb <= 4'hf;
        rd(12'h094, 32'h5a, QPF_RESP_OKAY);
        rd(12'h000, 32'h5a, QPF_RESP_OKAY);
        wr(12'h3cc, 32'h77);
        rd(12'h1cc, 32'h77, QPF_RESP_OKAY);
        rd(12'h800, 32'h0, QPF_RESP_SLVERR);
        // run bit cleared: divider and program counter stand still
        rd(12'h400, 32'h1, QPF_RESP_OKAY);
        mon <= 0;
        wr(12'h400, 32'h0);
        pc_h = O_PROG_ADDR;
        repeat (8) @(posedge I_MCLK);
        `CHK(O_PROG_ADDR, pc_h)
        `CHK(O_PHASE, ph_q)
        wr(12'h400, 32'h1);
        mon <= 1;
        // random storage locations; special-register rows steered away
        for (int k = 0; k < 12; k++) begin
            r = xs();
            idx = r[15:8];
            if (idx[6:5] == 2'b00) idx[6] = 1'b1;
            wr({2'b00, idx, 2'b00}, r);
            rd({2'b00, idx, 2'b00}, exp_rd(idx, r), QPF_RESP_OKAY);
        end
        conclude();
    end
endmodule // testbench
